// [fmsp_top.sv]
// two identical four-mode serial ports behind a byte-wide register port
// assumes timers 1 and 2 live outside and pulse their overflows on clk
`timescale 1ns/1ps
`include "fmsp_map.svh"

// ============================================================
// one serial port
module fmsp_port #(
    parameter logic [7:0] CTRL_ADDR = `FMSP_CTRL0_ADDR,
    parameter logic [7:0] DATA_ADDR = `FMSP_DATA0_ADDR
) (
    input wire logic clk,
    input wire logic rst,
    input fmsp_pkg::fmsp_sfr_req_s req,
    input wire logic rxd_in,
    input wire logic baud_doubler,
    input wire logic tx_timer2_select,
    input wire logic rx_timer2_select,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output fmsp_pkg::fmsp_pins_s pins
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_buf;
        fmsp_pkg::fmsp_tx_e tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_cnt;
        logic [3:0] tx_ph;
        fmsp_pkg::fmsp_rx_e rx_st;
        logic [9:0] rx_sh;
        logic [3:0] rx_idx;
        logic [3:0] rx_ph;
        logic [1:0] rx_smp;
        logic rx_prev;
        fmsp_pkg::fmsp_pins_s pins;
    } fmsp_port_s;

    fmsp_port_s s;
    fmsp_port_s n;
    fmsp_pkg::fmsp_ticks_s tk;
    logic rx_now;
    logic wr_ctrl;
    logic wr_data;
    logic [1:0] mode;
    logic ti_set;
    logic ri_set;
    logic rb8_load;
    logic rb8_val;
    logic rxb_load;
    logic [7:0] rxb_val;
    logic decide;
    logic bit_val;
    logic ninth;

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic is_mode0(input logic [1:0] m);
        is_mode0 = (m == `FMSP_MODE0);
    endfunction

    fmsp_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin(rxd_in),
        .level(rx_now)
    );

    assign mode = {s.ctrl[`FMSP_MSEL_HI], s.ctrl[`FMSP_MSEL_LO]};

    fmsp_baud u_baud (
        .clk(clk),
        .rst(rst),
        .mode(mode),
        .baud_doubler(baud_doubler),
        .tx_timer2_select(tx_timer2_select),
        .rx_timer2_select(rx_timer2_select),
        .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf),
        .ticks(tk)
    );

    // ============================================================
    // register decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_data = 1'b0;
        rd_hit = 1'b0;
        rd_data = `FMSP_UNMAPPED_READ;
        if (req.addr == CTRL_ADDR) begin
            wr_ctrl = req.wr;
            rd_hit = req.rd;
            rd_data = s.ctrl;
        end else if (req.addr == DATA_ADDR) begin
            wr_data = req.wr;
            rd_hit = req.rd;
            rd_data = s.rx_buf;
        end
    end

    // ============================================================
    // next state
    always_comb begin
        n = s;
        ti_set = 1'b0;
        ri_set = 1'b0;
        rb8_load = 1'b0;
        rb8_val = 1'b0;
        rxb_load = 1'b0;
        rxb_val = `FMSP_BUF_RST;
        ninth = 1'b0;
        decide = tk.rx_s16 && (s.rx_ph == `FMSP_SMP_LAST);
        bit_val = majority({s.rx_smp, rx_now});
        if (wr_ctrl) begin
            n.ctrl = req.wdata;
        end

        // transmitter, independent of the receiver below
        if (tk.tx_s16) begin
            n.tx_ph = s.tx_ph + 4'h1;
        end
        case (s.tx_st)
            fmsp_pkg::FMSP_TX_SHIFT0: begin
                if (tk.m0_tick) begin
                    if (s.tx_cnt == 4'h0) begin
                        n.tx_st = fmsp_pkg::FMSP_TX_IDLE;
                        n.pins.rxd_oe = 1'b0;
                        n.pins.rxd_out = `FMSP_LINE_IDLE;
                        ti_set = 1'b1;
                    end else begin
                        n.pins.rxd_oe = 1'b1;
                        n.pins.rxd_out = s.tx_sh[0];
                        n.pins.txd_out = 1'b0;
                        n.tx_sh = {1'b0, s.tx_sh[10:1]};
                        n.tx_cnt = s.tx_cnt - 4'h1;
                    end
                end else if (tk.m0_half) begin
                    n.pins.txd_out = 1'b1;
                end
            end
            fmsp_pkg::FMSP_TX_ASYNC: begin
                if (tk.tx_s16 && s.tx_ph == `FMSP_S16_LAST) begin
                    if (s.tx_cnt == 4'h0) begin
                        n.tx_st = fmsp_pkg::FMSP_TX_IDLE;
                        n.pins.txd_out = `FMSP_LINE_IDLE;
                    end else begin
                        n.pins.txd_out = s.tx_sh[0];
                        n.tx_sh = {1'b1, s.tx_sh[10:1]};
                        n.tx_cnt = s.tx_cnt - 4'h1;
                        // last bit out is the stop bit
                        ti_set = (s.tx_cnt == 4'h1);
                    end
                end
            end
            default: begin
            end
        endcase
        // a write mid-frame restarts with the new byte
        if (wr_data) begin
            if (is_mode0(mode)) begin
                n.tx_st = fmsp_pkg::FMSP_TX_SHIFT0;
                n.tx_sh = {3'h0, req.wdata};
                n.tx_cnt = `FMSP_M0_BITS;
            end else if (mode == `FMSP_MODE1) begin
                n.tx_st = fmsp_pkg::FMSP_TX_ASYNC;
                // async frames leave on the transmit line only
                n.pins.rxd_oe = 1'b0;
                n.tx_sh = {2'h3, req.wdata, 1'b0};
                n.tx_cnt = `FMSP_M1_TX_BITS;
            end else begin
                n.tx_st = fmsp_pkg::FMSP_TX_ASYNC;
                n.pins.rxd_oe = 1'b0;
                n.tx_sh = {1'b1, s.ctrl[`FMSP_TB8], req.wdata, 1'b0};
                n.tx_cnt = `FMSP_M23_TX_BITS;
            end
        end

        // receiver, sampled at sixteen times the bit rate in modes 1 to 3, once per bit in mode 0
        if (tk.rx_s16) begin
            n.rx_prev = rx_now;
            n.rx_ph = s.rx_ph + 4'h1;
            if (s.rx_ph >= `FMSP_SMP_FIRST && s.rx_ph < `FMSP_SMP_LAST) begin
                n.rx_smp = {s.rx_smp[0], rx_now};
            end
        end
        case (s.rx_st)
            fmsp_pkg::FMSP_RX_IDLE: begin
                if (is_mode0(mode)) begin
                    // shared pins: wait for the transmitter to finish
                    if (s.ctrl[`FMSP_REN] && !s.ctrl[`FMSP_RI] &&
                        s.tx_st == fmsp_pkg::FMSP_TX_IDLE) begin
                        n.rx_st = fmsp_pkg::FMSP_RX_SHIFT0;
                        n.rx_idx = 4'h0;
                    end
                end else if (s.ctrl[`FMSP_REN] && tk.rx_s16 &&
                             s.rx_prev && !rx_now) begin
                    n.rx_st = fmsp_pkg::FMSP_RX_START;
                    n.rx_ph = 4'h1;
                end
            end
            fmsp_pkg::FMSP_RX_SHIFT0: begin
                if (tk.m0_tick) begin
                    if (s.rx_idx == `FMSP_M0_BITS) begin
                        n.rx_st = fmsp_pkg::FMSP_RX_IDLE;
                        n.pins.txd_out = `FMSP_LINE_IDLE;
                        rxb_load = 1'b1;
                        rxb_val = s.rx_sh[7:0];
                        ri_set = 1'b1;
                    end else begin
                        n.pins.txd_out = 1'b0;
                        n.rx_idx = s.rx_idx + 4'h1;
                    end
                end else if (tk.m0_half && s.rx_idx != 4'h0) begin
                    n.pins.txd_out = 1'b1;
                    n.rx_sh[7:0] = {rx_now, s.rx_sh[7:1]};
                end
            end
            fmsp_pkg::FMSP_RX_START: begin
                if (decide) begin
                    // a glitch that is high at mid-bit is no start bit
                    if (bit_val) begin
                        n.rx_st = fmsp_pkg::FMSP_RX_IDLE;
                    end else begin
                        n.rx_st = fmsp_pkg::FMSP_RX_DATA;
                        n.rx_idx = 4'h0;
                    end
                end
            end
            fmsp_pkg::FMSP_RX_DATA: begin
                if (decide) begin
                    n.rx_sh[s.rx_idx] = bit_val;
                    if ((mode == `FMSP_MODE1 &&
                         s.rx_idx == `FMSP_M1_RX_LAST) ||
                        (mode != `FMSP_MODE1 &&
                         s.rx_idx == `FMSP_M23_RX_LAST)) begin
                        n.rx_st = fmsp_pkg::FMSP_RX_IDLE;
                        ninth = (mode == `FMSP_MODE1) ? bit_val : s.rx_sh[8];
                        // unread byte wins; the new one is dropped
                        if (!s.ctrl[`FMSP_RI] &&
                            (!s.ctrl[`FMSP_MPF] || ninth)) begin
                            rxb_load = 1'b1;
                            rxb_val = s.rx_sh[7:0];
                            rb8_load = 1'b1;
                            rb8_val = ninth;
                            ri_set = 1'b1;
                        end
                    end else begin
                        n.rx_idx = s.rx_idx + 4'h1;
                    end
                end
            end
            default: begin
                n.rx_st = fmsp_pkg::FMSP_RX_IDLE;
            end
        endcase

        // hardware sets win over a software clear in the same cycle
        if (rxb_load) begin
            n.rx_buf = rxb_val;
        end
        if (rb8_load) begin
            n.ctrl[`FMSP_RB8] = rb8_val;
        end
        if (ti_set) begin
            n.ctrl[`FMSP_TI] = 1'b1;
        end
        if (ri_set) begin
            n.ctrl[`FMSP_RI] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= `FMSP_CTRL_RST;
            s.rx_buf <= `FMSP_BUF_RST;
            s.tx_st <= fmsp_pkg::FMSP_TX_IDLE;
            s.rx_st <= fmsp_pkg::FMSP_RX_IDLE;
            s.rx_prev <= `FMSP_LINE_IDLE;
            s.pins.rxd_out <= `FMSP_LINE_IDLE;
            s.pins.txd_out <= `FMSP_LINE_IDLE;
        end else begin
            s <= n;
        end
    end

    assign pins = s.pins;

    // ============================================================
    // checks
    a_ti_hold:
    assert property (@(posedge clk) disable iff (rst)
        s.ctrl[`FMSP_TI] && !wr_ctrl |=> s.ctrl[`FMSP_TI])
        else $error("transmit flag dropped without a write");

    a_ri_hold:
    assert property (@(posedge clk) disable iff (rst)
        s.ctrl[`FMSP_RI] && !wr_ctrl |=> s.ctrl[`FMSP_RI])
        else $error("receive flag dropped without a write");

    a_tx_launch:
    assert property (@(posedge clk) disable iff (rst)
        wr_data && !is_mode0(mode) |=>
        s.tx_st == fmsp_pkg::FMSP_TX_ASYNC && s.tx_cnt != 4'h0)
        else $error("data write did not start a frame");

    a_ren_gate:
    assert property (@(posedge clk) disable iff (rst)
        s.rx_st == fmsp_pkg::FMSP_RX_IDLE && !s.ctrl[`FMSP_REN] |=>
        s.rx_st == fmsp_pkg::FMSP_RX_IDLE)
        else $error("reception started while disabled");

    a_oe_shift0:
    assert property (@(posedge clk) disable iff (rst)
        s.pins.rxd_oe |-> s.tx_st == fmsp_pkg::FMSP_TX_SHIFT0)
        else $error("data pin driven outside a shift transmit");

    a_ti_stop:
    assert property (@(posedge clk) disable iff (rst)
        $rose(s.ctrl[`FMSP_TI]) && !$past(wr_ctrl) &&
        s.tx_st == fmsp_pkg::FMSP_TX_ASYNC |->
        s.tx_cnt == 4'h0 && s.pins.txd_out)
        else $error("transmit flag not at the stop bit");

    a_mpf_filter:
    assert property (@(posedge clk) disable iff (rst)
        $rose(s.ctrl[`FMSP_RI]) && !$past(wr_ctrl) &&
        mode[1] && s.ctrl[`FMSP_MPF] |-> s.ctrl[`FMSP_RB8])
        else $error("filtered frame raised the receive flag");

    a_buf_keep:
    assert property (@(posedge clk) disable iff (rst)
        s.ctrl[`FMSP_RI] && !wr_ctrl |=> $stable(s.rx_buf))
        else $error("unread byte overwritten");

    a_idle_line:
    assert property (@(posedge clk) disable iff (rst)
        s.tx_st == fmsp_pkg::FMSP_TX_IDLE &&
        s.rx_st != fmsp_pkg::FMSP_RX_SHIFT0 |-> s.pins.txd_out)
        else $error("transmit line not high while idle");
endmodule

// ============================================================
module fmsp_top (
    input wire logic clk,
    input wire logic rst,
    input fmsp_pkg::fmsp_sfr_req_s req,
    output logic [7:0] rdata,
    input wire logic [1:0] rxd_in,
    input wire logic [1:0] baud_doubler,
    input wire logic [1:0] tx_timer2_select,
    input wire logic [1:0] rx_timer2_select,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    output fmsp_pkg::fmsp_pins_s port0_pins,
    output fmsp_pkg::fmsp_pins_s port1_pins
);
    typedef struct packed {
        logic [7:0] rdata;
    } fmsp_top_s;

    fmsp_top_s state_reg;
    fmsp_top_s state_next;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic hit0;
    logic hit1;

    fmsp_port #(
        .CTRL_ADDR(`FMSP_CTRL0_ADDR),
        .DATA_ADDR(`FMSP_DATA0_ADDR)
    ) u_port0 (
        .clk(clk),
        .rst(rst),
        .req(req),
        .rxd_in(rxd_in[0]),
        .baud_doubler(baud_doubler[0]),
        .tx_timer2_select(tx_timer2_select[0]),
        .rx_timer2_select(rx_timer2_select[0]),
        .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf),
        .rd_data(rd0),
        .rd_hit(hit0),
        .pins(port0_pins)
    );

    fmsp_port #(
        .CTRL_ADDR(`FMSP_CTRL1_ADDR),
        .DATA_ADDR(`FMSP_DATA1_ADDR)
    ) u_port1 (
        .clk(clk),
        .rst(rst),
        .req(req),
        .rxd_in(rxd_in[1]),
        .baud_doubler(baud_doubler[1]),
        .tx_timer2_select(tx_timer2_select[1]),
        .rx_timer2_select(rx_timer2_select[1]),
        .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf),
        .rd_data(rd1),
        .rd_hit(hit1),
        .pins(port1_pins)
    );

    // read data is registered: answer one cycle after the strobe
    always_comb begin
        state_next.rdata = `FMSP_UNMAPPED_READ;
        if (hit0) begin
            state_next.rdata = rd0;
        end else if (hit1) begin
            state_next.rdata = rd1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
endmodule

// [fmsp_map.svh]
// register addresses, field positions and timing counts of the serial port
// assumes it is included by bare name wherever a constant is needed
`ifndef FMSP_MAP_SVH
`define FMSP_MAP_SVH

// ============================================================
// special function register addresses
`define FMSP_CTRL0_ADDR 8'h10
`define FMSP_DATA0_ADDR 8'h11
`define FMSP_CTRL1_ADDR 8'h12
`define FMSP_DATA1_ADDR 8'h13
`define FMSP_UNMAPPED_READ 8'h00

// ============================================================
// control and status fields
`define FMSP_MSEL_HI 7
`define FMSP_MSEL_LO 6
`define FMSP_MPF 5
`define FMSP_REN 4
`define FMSP_TB8 3
`define FMSP_RB8 2
`define FMSP_TI 1
`define FMSP_RI 0
`define FMSP_CTRL_RST 8'h00
`define FMSP_BUF_RST 8'h00

// ============================================================
// mode codes, {high, low}
`define FMSP_MODE0 2'h0
`define FMSP_MODE1 2'h1
`define FMSP_MODE2 2'h2
`define FMSP_MODE3 2'h3

// ============================================================
// timing counts
`define FMSP_M0_LAST 4'hb
`define FMSP_M0_HALF 4'h5
`define FMSP_M2_SLOW_LAST 2'h3
`define FMSP_S16_LAST 4'hf
`define FMSP_SMP_FIRST 4'h7
`define FMSP_SMP_LAST 4'h9
`define FMSP_M0_BITS 4'h8
`define FMSP_M1_TX_BITS 4'ha
`define FMSP_M23_TX_BITS 4'hb
`define FMSP_M1_RX_LAST 4'h8
`define FMSP_M23_RX_LAST 4'h9
`define FMSP_LINE_IDLE 1'b1

`endif

// [fmsp_pkg.sv]
// types shared by the serial port modules
// assumes fmsp_map.svh supplies the numeric constants
package fmsp_pkg;

    // ============================================================
    // state codes
    typedef enum logic [2:0] {
        FMSP_TX_IDLE = 3'b001,
        FMSP_TX_SHIFT0 = 3'b010,
        FMSP_TX_ASYNC = 3'b100
    } fmsp_tx_e;

    typedef enum logic [3:0] {
        FMSP_RX_IDLE = 4'b0001,
        FMSP_RX_SHIFT0 = 4'b0010,
        FMSP_RX_START = 4'b0100,
        FMSP_RX_DATA = 4'b1000
    } fmsp_rx_e;

    // ============================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } fmsp_sfr_req_s;

    typedef struct packed {
        logic rxd_out;
        logic rxd_oe;
        logic txd_out;
    } fmsp_pins_s;

    typedef struct packed {
        logic m0_tick;
        logic m0_half;
        logic tx_s16;
        logic rx_s16;
    } fmsp_ticks_s;

endpackage

// [fmsp_sync.sv]
// three-stage synchroniser for one pin input
// assumes the pin is asynchronous to clk; output holds until two stages agree
`timescale 1ns/1ps
`include "fmsp_map.svh"
module fmsp_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic val;
    } fmsp_sync_s;

    fmsp_sync_s state_reg;
    fmsp_sync_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.s1 = pin;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        if (state_reg.s2 == state_reg.s3) begin
            state_next.val = state_reg.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= {4{`FMSP_LINE_IDLE}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.val;
endmodule

// [fmsp_baud.sv]
// bit-rate tick generator for one serial port
// assumes timer overflow inputs are one-cycle pulses on clk
`timescale 1ns/1ps
`include "fmsp_map.svh"
module fmsp_baud (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic baud_doubler,
    input wire logic tx_timer2_select,
    input wire logic rx_timer2_select,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    output fmsp_pkg::fmsp_ticks_s ticks
);
    typedef struct packed {
        logic [3:0] m0_cnt;
        logic [1:0] m2_cnt;
        logic t1_half;
        fmsp_pkg::fmsp_ticks_s tk;
    } fmsp_baud_s;

    fmsp_baud_s state_reg;
    fmsp_baud_s state_next;
    logic m2_tick;
    logic t1_tick;

    // ticks are at sixteen times the bit rate for the async modes
    always_comb begin
        state_next = state_reg;
        if (state_reg.m0_cnt == `FMSP_M0_LAST) begin
            state_next.m0_cnt = 4'h0;
        end else begin
            state_next.m0_cnt = state_reg.m0_cnt + 4'h1;
        end
        state_next.tk.m0_tick = (state_reg.m0_cnt == `FMSP_M0_LAST);
        state_next.tk.m0_half = (state_reg.m0_cnt == `FMSP_M0_HALF);
        state_next.m2_cnt = state_reg.m2_cnt + 2'h1;
        if (baud_doubler) begin
            m2_tick = state_reg.m2_cnt[0];
        end else begin
            m2_tick = (state_reg.m2_cnt == `FMSP_M2_SLOW_LAST);
        end
        if (timer1_ovf) begin
            state_next.t1_half = ~state_reg.t1_half;
        end
        t1_tick = timer1_ovf && (baud_doubler || state_reg.t1_half);
        if (mode == `FMSP_MODE2) begin
            state_next.tk.tx_s16 = m2_tick;
            state_next.tk.rx_s16 = m2_tick;
        end else begin
            state_next.tk.tx_s16 = tx_timer2_select ? timer2_ovf : t1_tick;
            state_next.tk.rx_s16 = rx_timer2_select ? timer2_ovf : t1_tick;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ticks = state_reg.tk;
endmodule

// [fmsp_peer.sv]
// remote serial peer: drives one receive line, samples one transmit line
// assumes bit time is given in clk cycles and both lines idle high
`timescale 1ns/1ps
module fmsp_peer (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    initial line_out = 1'b1;
    // ============================================================
    // frame pattern is lsb first, start bit in bit 0
    task automatic send(input logic [10:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (per) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask
    // samples at mid-bit, so a wrong bit rate drifts out of the frame
    task automatic grab(output logic [10:0] bits, input int n, input int per);
        bits = '0;
        @(negedge line_in);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            bits[i] = line_in;
            repeat (per) @(posedge clk);
        end
    endtask
endmodule

// [tb.sv]
// self-checking bench for the two serial ports
// assumes 125 MHz clk, peers on both lines, timer 1 pulsing every 2 clk
`timescale 1ns/1ps
`include "fmsp_map.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic clk, rst, rx0, rx1, t1, t2;
    logic [7:0] rdata, d, r;
    logic [10:0] f;
    logic [1:0] dbl, t2sel;
    fmsp_pkg::fmsp_sfr_req_s req;
    fmsp_pkg::fmsp_pins_s pins0, pins1;
    int err_total, checks, cyc;
    fmsp_top dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .rxd_in({rx1, rx0}), .baud_doubler(dbl), .tx_timer2_select(t2sel),
        .rx_timer2_select(t2sel), .timer1_ovf(t1), .timer2_ovf(t2),
        .port0_pins(pins0), .port1_pins(pins1));
    fmsp_peer p0 (.clk(clk), .line_in(pins0.txd_out), .line_out(rx0));
    fmsp_peer p1 (.clk(clk), .line_in(pins1.txd_out), .line_out(rx1));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ceiling well above the ~4000 cycles the frames need
    always @(posedge clk) begin
        #1 t2 = t1;
        t1 = ~t1;
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        #1 req.rd = 1'b0;
        v = rdata;
    endtask
    function automatic logic [10:0] frm(input logic [7:0] v, input logic nb);
        return {1'b1, nb, v, 1'b0};
    endfunction
    initial begin
        req = '0;
        rst = 1'b1;
        t1 = 1'b0;
        t2 = 1'b0;
        dbl = 2'h3;
        t2sel = 2'h0;
        cyc = 0;
        err_total = 0;
        checks = 0;
        d = $urandom(32'hd4d1de7f);
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        rd(`FMSP_CTRL0_ADDR, r);
        `CHK(r, 8'h00)
        rd(`FMSP_DATA1_ADDR, r);
        `CHK(r, 8'h00)
        $display("test reset done");
        wr(`FMSP_CTRL0_ADDR, 8'h00);
        d = $urandom;
        wr(`FMSP_DATA0_ADDR, d);
        for (int i = 0; i < 8; i++) begin
            @(posedge pins0.txd_out);
            `CHK(pins0.rxd_oe, 1'b1)
            r = {pins0.rxd_out, r[7:1]};
        end
        `CHK(r, d)
        repeat (10) @(posedge clk);
        `CHK(pins0.rxd_oe, 1'b0)
        rd(`FMSP_CTRL0_ADDR, r);
        `CHK(r[1], 1'b1)
        $display("test mode 0 transmit done");
        for (int k = 0; k < 2; k++) begin
            d = $urandom;
            dbl = {1'b1, k[0]};
            wr(`FMSP_CTRL0_ADDR, {4'h8, k[0], 3'h0});
            fork
                p0.grab(f, 11, k ? 32 : 64);
                wr(`FMSP_DATA0_ADDR, d);
            join
            `CHK(f, frm(d, k[0]))
            rd(`FMSP_CTRL0_ADDR, r);
            `CHK(r[1], 1'b1)
        end
        $display("test mode 2 transmit done");
        wr(`FMSP_CTRL0_ADDR, 8'hb0);
        for (int k = 0; k < 3; k++) begin
            if (k < 2) begin
                d = $urandom;
            end
            p0.send(frm(k < 2 ? d : ~d, k != 0), 11, 32);
            repeat (40) @(posedge clk);
            rd(`FMSP_CTRL0_ADDR, r);
            `CHK(r[2:0], k ? 3'h5 : 3'h0)
            rd(`FMSP_DATA0_ADDR, r);
            `CHK(r, k ? d : 8'h00)
        end
        $display("test mode 2 filtered receive done");
        // transmit and receive overlap on port 1 on the second pass; the first leaves REN clear
        for (int k = 0; k < 2; k++) begin
            d = $urandom;
            dbl = {k[0], 1'b1};
            wr(`FMSP_CTRL1_ADDR, k ? 8'h70 : 8'h40);
            fork
                p1.grab(f, 10, k ? 32 : 64);
                wr(`FMSP_DATA1_ADDR, ~d);
                p1.send(frm(d, 1'b1), 10, k ? 32 : 64);
            join
            `CHK(f[9:0], {1'b1, ~d, 1'b0})
            repeat (20) @(posedge clk);
            rd(`FMSP_CTRL1_ADDR, r);
            `CHK(r[2:0], k ? 3'h7 : 3'h2)
        end
        rd(`FMSP_DATA1_ADDR, r);
        `CHK(r, d)
        $display("test mode 1 duplex done");
        d = $urandom;
        t2sel = 2'h2;
        wr(`FMSP_CTRL1_ADDR, 8'hd8);
        fork
            p1.grab(f, 11, 32);
            wr(`FMSP_DATA1_ADDR, ~d);
            p1.send(frm(d, 1'b0), 11, 32);
        join
        `CHK(f, frm(~d, 1'b1))
        repeat (20) @(posedge clk);
        rd(`FMSP_CTRL1_ADDR, r);
        `CHK(r[2:0], 3'h3)
        rd(`FMSP_DATA1_ADDR, r);
        `CHK(r, d)
        $display("test mode 3 timer 2 done");
        print_verdict();
    end
endmodule
